// [rtl/tws_cfg.svh]
`ifndef TWS_CFG_SVH
`define TWS_CFG_SVH
// register indices on the plain port
`define TWS_ADDR_CTRL 2'h0
`define TWS_ADDR_DATA 2'h1
`define TWS_ADDR_SVA 2'h2
`define TWS_ADDR_STAT 2'h3
// control fields
`define TWS_CTRL_EN 0
`define TWS_CTRL_WUP 1
`define TWS_CTRL_BUS 2
`define TWS_CTRL_MST 3
`define TWS_CTRL_COMMAND_TRIGGER_BIT 4
`define TWS_CTRL_RELEASE_TRIGGER_BIT 5
// status fields
`define TWS_ST_DONE 0
`define TWS_ST_MATCH 1
`define TWS_ST_ACTIVE 2
`define TWS_ST_SEL 3
`define TWS_ST_RELD 4
`define TWS_ST_CMDD 5
// reset values
`define TWS_SR_RST 8'h00
`define TWS_SVA_RST 8'h00
`define TWS_LATCH_RST 1'b1
`define TWS_LAST_BIT 3'h7
// timing
`define TWS_CLK_FREQ_MHZ 20
`define TWS_SCK_HALF_NS 1000
`define TWS_SCK_HALF_CYC ((`TWS_SCK_HALF_NS * `TWS_CLK_FREQ_MHZ) / 1000)
`endif

// [rtl/tws_pkg.sv]
package tws_pkg;
   typedef enum logic [2:0] {
      TWS_IDLE = 3'b001,
      TWS_SHIFT = 3'b010,
      TWS_HOLD = 3'b100
   } tws_state_e;
   typedef enum logic [1:0] {
      TWS_CLS_DATA = 2'h0,
      TWS_CLS_CMD = 2'h1,
      TWS_CLS_ADDR = 2'h2
   } tws_class_e;
endpackage

// [rtl/tws_bus_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface tws_bus_if;
   logic dev_sck_o;
   logic dev_sck_oe;
   logic dev_sda_o;
   logic dev_sda_oe;
   logic par_sck_o;
   logic par_sck_oe;
   logic par_sda_o;
   logic par_sda_oe;
   logic sck;
   logic sda;
   // wired lines with pull-up: low while any driver pulls low
   assign sck = !((dev_sck_oe & !dev_sck_o) | (par_sck_oe & !par_sck_o));
   assign sda = !((dev_sda_oe & !dev_sda_o) | (par_sda_oe & !par_sda_o));
   modport dev (output dev_sck_o, dev_sck_oe, dev_sda_o, dev_sda_oe,
      input sck, sda);
   modport par (output par_sck_o, par_sck_oe, par_sda_o, par_sda_oe,
      input sck, sda);
endinterface
`default_nettype wire

// [rtl/tws_device.sv]
// Overview of operation
// - data write with enable, idle, starts transfer
// - setting enable later never starts transfer
// - receiver preloads all ones before receiving
// - eighth bit stops shifting, sets done flag
// - transmitted line level captured into shift register
// - same byte in address register checks errors
// - hardware classifies address, command, data bytes
// - wake-up: done only on own address
// - master drives conditions, slave busy, either ack
// - master clocks until slave releases busy
// - data rise with clock high idle: release
// - data fall with clock high idle: command
// - byte after release and command is address
// - byte after command is command, else data
// - data line open-drain, pull low only
// - shift out on fall msb first, in on rise
// - triggers clear or set latch, self-clearing
// - match flag compares address and shift registers
`include "tws_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tws_device
   import tws_pkg::*;
#(
   parameter int HALF_CYC = `TWS_SCK_HALF_CYC
) (
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   tws_bus_if.dev bus,
   input wire logic [1:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o
);
   localparam int DW = $clog2(HALF_CYC + 1);

   // ----------------------------------------
   // line synchronisers
   // ----------------------------------------
   logic sck_m, sck_s, sck_d, sda_m, sda_s, sda_d;
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         {sck_m, sck_s, sck_d} <= 3'h7;
         {sda_m, sda_s, sda_d} <= 3'h7;
      end else begin
         {sck_m, sck_s, sck_d} <= {bus.sck, sck_m, sck_s};
         {sda_m, sda_s, sda_d} <= {bus.sda, sda_m, sda_s};
      end
   end
   wire sck_rise = sck_s & !sck_d;
   wire sck_fall = !sck_s & sck_d;

   // ----------------------------------------
   // registers and decode
   // ----------------------------------------
   logic en, wake_up_enable, bmode, mst, latch, done, rel_seen, cmd_seen, selected;
   logic sck_drv;
   logic [7:0] sr, slave_address_register;
   logic [2:0] cnt;
   logic [DW-1:0] div;
   tws_state_e state;
   tws_class_e cls;

   wire st_idle = (state == TWS_IDLE);
   wire st_shift = (state == TWS_SHIFT);
   wire wr_ctrl = wr_i & (addr_i == `TWS_ADDR_CTRL);
   wire wr_data = wr_i & (addr_i == `TWS_ADDR_DATA);
   wire wr_sva = wr_i & (addr_i == `TWS_ADDR_SVA);
   wire wr_stat = wr_i & (addr_i == `TWS_ADDR_STAT);
   wire command_trigger_bit = wr_ctrl & wdata_i[`TWS_CTRL_COMMAND_TRIGGER_BIT];
   wire release_trigger_bit = wr_ctrl & wdata_i[`TWS_CTRL_RELEASE_TRIGGER_BIT];
   wire start = wr_data & en & st_idle & (mst | sck_s);
   wire byte_end = st_shift & sck_rise & (cnt == `TWS_LAST_BIT);
   wire [7:0] sr_in = {sr[6:0], sda_s};

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         {mst, bmode, wake_up_enable, en} <= 4'h0;
         slave_address_register <= `TWS_SVA_RST;
      end else begin
         if (wr_ctrl) begin
            en <= wdata_i[`TWS_CTRL_EN];
            wake_up_enable <= wdata_i[`TWS_CTRL_WUP];
            bmode <= wdata_i[`TWS_CTRL_BUS];
            mst <= wdata_i[`TWS_CTRL_MST];
         end
         if (wr_sva) begin
            slave_address_register <= wdata_i;
         end
      end
   end

   // ----------------------------------------
   // shift engine
   // ----------------------------------------
   wire hold_go = byte_end & mst & bmode;
   wire hold_end = (state == TWS_HOLD) & sck_rise & sda_s;
   tws_state_e next_state;
   assign next_state = start ? TWS_SHIFT :
                       hold_go ? TWS_HOLD :
                       (byte_end | hold_end | !en) ? TWS_IDLE : state;

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state <= TWS_IDLE;
         cnt <= 3'h0;
         sr <= `TWS_SR_RST;
      end else begin
         state <= next_state;
         if (start) begin
            cnt <= 3'h0;
         end else if (st_shift & sck_rise) begin
            cnt <= cnt + 3'h1;
         end
         if (wr_data & st_idle) begin
            sr <= wdata_i;
         end else if (st_shift & sck_rise) begin
            sr <= sr_in;
         end
      end
   end

   // output latch: msb out on falling edge, triggers set or clear it
   logic next_latch;
   assign next_latch = release_trigger_bit ? 1'b1 :
                       command_trigger_bit ? 1'b0 :
                       hold_go ? 1'b1 :
                       (st_shift & sck_fall) ? sr[7] : latch;

   // ----------------------------------------
   // bus conditions and byte class
   // ----------------------------------------
   // only while clock idle high
   wire idle_hi = st_idle & sck_s & sck_d & en & bmode;
   wire rel_det = idle_hi & sda_s & !sda_d;
   wire cmd_det = idle_hi & !sda_s & sda_d;
   wire match_now = (sr_in == slave_address_register);
   wire is_addr = bmode & rel_seen & cmd_seen;
   wire is_cmd = bmode & cmd_seen & !rel_seen;
   wire done_set = byte_end & (!(wake_up_enable & bmode) | (is_addr & match_now));
   wire done_clr = wr_stat & wdata_i[`TWS_ST_DONE];

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         latch <= `TWS_LATCH_RST;
         done <= 1'b0;
         rel_seen <= 1'b0;
         cmd_seen <= 1'b0;
         selected <= 1'b0;
         cls <= TWS_CLS_DATA;
      end else begin
         latch <= next_latch;
         done <= done_set | (done & !done_clr);
         rel_seen <= rel_det | (rel_seen & !byte_end & en);
         cmd_seen <= cmd_det | (cmd_seen & !byte_end & !rel_det & en);
         if (byte_end) begin
            cls <= is_addr ? TWS_CLS_ADDR :
                   is_cmd ? TWS_CLS_CMD : TWS_CLS_DATA;
         end
         if (byte_end & is_addr) begin
            selected <= match_now;
         end
      end
   end

   // ----------------------------------------
   // master clock generator
   // ----------------------------------------
   wire run = !st_idle & mst & en;
   wire half = (div == DW'(HALF_CYC - 1));
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         div <= '0;
         sck_drv <= 1'b1;
      end else if (!run) begin
         div <= '0;
         sck_drv <= 1'b1;
      end else begin
         // clocks run through the hold state
         div <= half ? '0 : div + DW'(1);
         sck_drv <= half ? !sck_drv : sck_drv;
      end
   end

   // ----------------------------------------
   // pin drivers
   // ----------------------------------------
   wire quiet = wake_up_enable & bmode & !selected;
   wire next_sda_oe = en & !quiet & !next_latch;
   wire next_sck_oe = run & !sck_drv;
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         bus.dev_sda_oe <= 1'b0;
         bus.dev_sck_oe <= 1'b0;
      end else begin
         bus.dev_sda_oe <= next_sda_oe;
         bus.dev_sck_oe <= next_sck_oe;
      end
   end
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         bus.dev_sda_o <= 1'b0;
         bus.dev_sck_o <= 1'b0;
      end else begin
         bus.dev_sda_o <= 1'b0;
         bus.dev_sck_o <= 1'b0;
      end
   end

   // ----------------------------------------
   // read port
   // ----------------------------------------
   // live comparator
   wire [7:0] stat_v = {cls, cmd_seen, rel_seen, selected, !st_idle,
                        (slave_address_register == sr), done};
   wire [7:0] ctrl_v = {4'h0, mst, bmode, wake_up_enable, en};
   wire [7:0] next_rdata = !rd_i ? 8'h00 :
                           (addr_i == `TWS_ADDR_CTRL) ? ctrl_v :
                           (addr_i == `TWS_ADDR_DATA) ? sr :
                           (addr_i == `TWS_ADDR_SVA) ? slave_address_register : stat_v;
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rdata_o <= 8'h00;
      end else begin
         rdata_o <= next_rdata;
      end
   end
endmodule
`default_nettype wire

// [rtl/tws_partner.sv]
`include "tws_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tws_partner
   import tws_pkg::*;
#(
   parameter int HALF_CYC = `TWS_SCK_HALF_CYC
) (
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   tws_bus_if.par bus,
   input wire logic [1:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o
);
   localparam int DW = $clog2(HALF_CYC + 1);

   // ----------------------------------------
   // line synchronisers
   // ----------------------------------------
   logic sck_m, sck_s, sck_d, sda_m, sda_s;
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         {sck_m, sck_s, sck_d} <= 3'h7;
         {sda_m, sda_s} <= 2'h3;
      end else begin
         {sck_m, sck_s, sck_d} <= {bus.sck, sck_m, sck_s};
         {sda_m, sda_s} <= {bus.sda, sda_m};
      end
   end
   wire sck_rise = sck_s & !sck_d;
   wire sck_fall = !sck_s & sck_d;

   // ----------------------------------------
   // master shift engine
   // ----------------------------------------
   logic latch, done, sck_drv;
   logic [7:0] sr;
   logic [2:0] cnt;
   logic [DW-1:0] div;
   tws_state_e state;
   wire st_idle = (state == TWS_IDLE);
   wire wr_ctrl = wr_i & (addr_i == `TWS_ADDR_CTRL);
   wire wr_data = wr_i & (addr_i == `TWS_ADDR_DATA);
   wire wr_stat = wr_i & (addr_i == `TWS_ADDR_STAT);
   // this end drives release and command
   wire command_trigger_bit = wr_ctrl & st_idle & wdata_i[`TWS_CTRL_COMMAND_TRIGGER_BIT];
   wire release_trigger_bit = wr_ctrl & st_idle & wdata_i[`TWS_CTRL_RELEASE_TRIGGER_BIT];
   // software writes all ones to receive
   wire start = wr_data & st_idle;
   wire byte_end = !st_idle & sck_rise & (cnt == `TWS_LAST_BIT);
   wire half = (div == DW'(HALF_CYC - 1));

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state <= TWS_IDLE;
         cnt <= 3'h0;
         sr <= `TWS_SR_RST;
      end else begin
         state <= start ? TWS_SHIFT : byte_end ? TWS_IDLE : state;
         if (start) begin
            cnt <= 3'h0;
            sr <= wdata_i;
         end else if (!st_idle & sck_rise) begin
            cnt <= cnt + 3'h1;
            sr <= {sr[6:0], sda_s};
         end
      end
   end

   // release latch rises with clock idle high
   // command latch falls with clock idle high
   wire next_latch = release_trigger_bit ? 1'b1 :
                     command_trigger_bit ? 1'b0 :
                     (!st_idle & sck_fall) ? sr[7] : latch;
   wire next_done = byte_end | (done & !(wr_stat & wdata_i[`TWS_ST_DONE]));
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         latch <= `TWS_LATCH_RST;
         done <= 1'b0;
         div <= '0;
         sck_drv <= 1'b1;
      end else begin
         latch <= next_latch;
         done <= next_done;
         div <= (st_idle | half) ? '0 : div + DW'(1);
         sck_drv <= st_idle ? 1'b1 : (half ? !sck_drv : sck_drv);
      end
   end

   // ----------------------------------------
   // pin drivers and read port
   // ----------------------------------------
   wire [7:0] next_rdata = !rd_i ? 8'h00 :
                           (addr_i == `TWS_ADDR_DATA) ? sr :
                           (addr_i == `TWS_ADDR_STAT) ?
                           {5'h0, !st_idle, 1'b0, done} : 8'h00;
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         bus.par_sda_oe <= 1'b0;
         bus.par_sck_oe <= 1'b0;
         bus.par_sda_o <= 1'b0;
         bus.par_sck_o <= 1'b0;
         rdata_o <= 8'h00;
      end else begin
         bus.par_sda_oe <= !next_latch;
         bus.par_sck_oe <= !st_idle & !sck_drv;
         bus.par_sda_o <= 1'b0;
         bus.par_sck_o <= 1'b0;
         rdata_o <= next_rdata;
      end
   end
endmodule
`default_nettype wire

// [test/tws_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module tws_chk #(
   parameter int HALF_CYC = 20
) (
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire logic dev_sck_o,
   input wire logic dev_sck_oe,
   input wire logic dev_sda_o,
   input wire logic dev_sda_oe,
   input wire logic par_sck_o,
   input wire logic par_sck_oe,
   input wire logic par_sda_o,
   input wire logic par_sda_oe,
   input wire logic sck,
   input wire logic sda
);
   // ------------------------------
   // line phase counters
   // ------------------------------
   localparam logic [7:0] HALF_C = 8'(HALF_CYC);
   localparam logic [7:0] IDLE_C = 8'(2 * HALF_CYC);
   logic [7:0] low_cnt;
   logic [7:0] hi_cnt;
   logic [3:0] pul_cnt;
   wire hi_idle = (hi_cnt == IDLE_C);
   wire in_byte = (pul_cnt != 4'h0) && (pul_cnt < 4'h8);
   wire byte_edge = (pul_cnt == 4'h0) || (pul_cnt == 4'h8);

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         low_cnt <= 8'h00;
      end else begin
         low_cnt <= sck ? 8'h00 : low_cnt + 8'h01;
      end
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         hi_cnt <= 8'h00;
      end else if (!sck) begin
         hi_cnt <= 8'h00;
      end else if (hi_cnt <= IDLE_C) begin
         hi_cnt <= hi_cnt + 8'h01;
      end
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pul_cnt <= 4'h0;
      end else if (hi_idle) begin
         pul_cnt <= 4'h0;
      end else if ($rose(sck)) begin
         pul_cnt <= pul_cnt + 4'h1;
      end
   end

   // ------------------------------
   // properties
   // ------------------------------
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!reset_n_i);

   sequence s_rise;
      $rose(sck);
   endsequence
   sequence s_quiet;
      $stable(sda) [*3];
   endsequence

   property p_sda_od;
      dev_sda_o == 1'b0 && par_sda_o == 1'b0;
   endproperty
   property p_sck_od;
      dev_sck_o == 1'b0 && par_sck_o == 1'b0;
   endproperty
   property p_reset_idle;
      $rose(reset_n_i) |-> !(dev_sda_oe || par_sda_oe || dev_sck_oe ||
         par_sck_oe);
   endproperty
   property p_hold_rise;
      s_rise |=> s_quiet;
   endproperty
   property p_half_low;
      s_rise |-> low_cnt == HALF_C;
   endproperty
   property p_gap;
      in_byte |-> hi_cnt <= HALF_C;
   endproperty
   property p_eight;
      hi_idle |-> byte_edge;
   endproperty
   property p_idle_edge;
      sck && $past(sck) && $changed(sda) |-> byte_edge;
   endproperty

   a_sda_od: assert property (p_sda_od)
      else $error("data line driven high");
   a_sck_od: assert property (p_sck_od)
      else $error("clock line driven high");
   a_reset_idle: assert property (p_reset_idle)
      else $error("line pulled low after reset");
   a_hold_rise: assert property (p_hold_rise)
      else $error("data moved around clock rise");
   a_half_low: assert property (p_half_low)
      else $error("clock low phase length wrong");
   a_gap: assert property (p_gap)
      else $error("clock stopped inside byte");
   a_eight: assert property (p_eight)
      else $error("byte not eight clock pulses");
   a_idle_edge: assert property (p_idle_edge)
      else $error("data edge with clock high in byte");
endmodule
`default_nettype wire

// [test/two_wire_serial_bus_interface_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module two_wire_serial_bus_interface_tb;
   localparam int HALF = 6;
   localparam logic [7:0] BYT [4] = '{8'h93, 8'h5b, 8'h81, 8'hc3};
   localparam logic [7:0] CTL [4] = '{8'h27, 8'h07, 8'h05, 8'h05};
   localparam logic [7:0] STX [4] = '{8'h80, 8'h89, 8'h49, 8'h09};
   logic clk_sys_i;
   logic reset_n_i;
   logic [1:0] addr [2];
   logic [7:0] wdata [2];
   logic wr [2];
   logic rd [2];
   logic [7:0] rdata [2];
   int failures = 0;
   int checks = 0;
   int cycles = 0;

   tws_bus_if tws_bus_if_i ();
   tws_device #(.HALF_CYC(HALF)) tws_device_i (.clk_sys_i(clk_sys_i),
      .reset_n_i(reset_n_i), .bus(tws_bus_if_i.dev), .addr_i(addr[0]),
      .wdata_i(wdata[0]), .wr_i(wr[0]), .rd_i(rd[0]), .rdata_o(rdata[0]));
   tws_partner #(.HALF_CYC(HALF)) tws_partner_i (.clk_sys_i(clk_sys_i),
      .reset_n_i(reset_n_i), .bus(tws_bus_if_i.par), .addr_i(addr[1]),
      .wdata_i(wdata[1]), .wr_i(wr[1]), .rd_i(rd[1]), .rdata_o(rdata[1]));
   tws_chk #(.HALF_CYC(HALF)) tws_chk_i (.clk_sys_i(clk_sys_i),
      .reset_n_i(reset_n_i), .dev_sck_o(tws_bus_if_i.dev_sck_o),
      .dev_sck_oe(tws_bus_if_i.dev_sck_oe),
      .dev_sda_o(tws_bus_if_i.dev_sda_o),
      .dev_sda_oe(tws_bus_if_i.dev_sda_oe),
      .par_sck_o(tws_bus_if_i.par_sck_o),
      .par_sck_oe(tws_bus_if_i.par_sck_oe),
      .par_sda_o(tws_bus_if_i.par_sda_o),
      .par_sda_oe(tws_bus_if_i.par_sda_oe),
      .sck(tws_bus_if_i.sck), .sda(tws_bus_if_i.sda));

   // ------------------------------
   // port access
   // ------------------------------
   task automatic tally_and_finish();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr_reg(input int p, input logic [1:0] a,
      input logic [7:0] d);
      @(posedge clk_sys_i);
      addr[p] <= a;
      wdata[p] <= d;
      wr[p] <= 1'b1;
      @(posedge clk_sys_i);
      wr[p] <= 1'b0;
   endtask

   task automatic rd_reg(input int p, input logic [1:0] a,
      output logic [7:0] v);
      @(posedge clk_sys_i);
      addr[p] <= a;
      rd[p] <= 1'b1;
      @(posedge clk_sys_i);
      rd[p] <= 1'b0;
      #1;
      v = rdata[p];
   endtask

   task automatic rc(input int p, input logic [1:0] a, input logic [7:0] m,
      input logic [7:0] exp);
      logic [7:0] v;
      rd_reg(p, a, v);
      chk(v & m, exp);
   endtask

   // partner sends one byte and waits for its done flag
   task automatic send(input logic [7:0] d);
      logic [7:0] v;
      wr_reg(1, 3, 8'h01);
      wr_reg(1, 1, d);
      v = 8'h00;
      for (int n = 0; n < 100 && v[0] !== 1'b1; n++) begin
         rd_reg(1, 3, v);
      end
      chk(v & 8'h05, 8'h01);
   endtask

   task automatic trig(input logic [7:0] code);
      wr_reg(1, 0, code);
      repeat (4) @(posedge clk_sys_i);
   endtask

   // ------------------------------
   // clock, reset, timeout
   // ------------------------------
   initial begin
      clk_sys_i = 1'b0;
      forever #25 clk_sys_i = ~clk_sys_i;
   end

   always @(posedge clk_sys_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures++;
         tally_and_finish();
      end
   end

   // ------------------------------
   // scenarios
   // ------------------------------
   initial begin
      logic [7:0] pd;
      reset_n_i = 1'b0;
      for (int p = 0; p < 2; p++) begin
         addr[p] = 2'h0;
         wdata[p] = 8'h00;
         wr[p] = 1'b0;
         rd[p] = 1'b0;
      end
      repeat (5) @(posedge clk_sys_i);
      reset_n_i <= 1'b1;
      rc(0, 0, 8'hff, 8'h00);
      rc(0, 3, 8'hff, 8'h02);
      rc(1, 3, 8'hff, 8'h00);
      wr_reg(0, 1, 8'h3c);
      wr_reg(0, 0, 8'h01);
      rc(0, 3, 8'hff, 8'h00);
      wr_reg(0, 0, 8'h11);
      repeat (3) @(posedge clk_sys_i);
      #1;
      chk({7'h00, tws_bus_if_i.sda}, 8'h00);
      rc(0, 0, 8'hff, 8'h01);
      wr_reg(0, 0, 8'h21);
      repeat (3) @(posedge clk_sys_i);
      #1;
      chk({7'h00, tws_bus_if_i.sda}, 8'h01);
      wr_reg(0, 1, 8'hff);
      rc(0, 3, 8'h04, 8'h04);
      send(8'ha5);
      rc(1, 1, 8'hff, 8'ha5);
      rc(0, 1, 8'hff, 8'ha5);
      rc(0, 3, 8'h05, 8'h01);
      wr_reg(0, 3, 8'h01);
      rc(0, 3, 8'h01, 8'h00);
      for (int i = 0; i < 2; i++) begin
         pd = (i == 0) ? 8'ha5 : 8'hff;
         wr_reg(0, 2, 8'h3c);
         wr_reg(0, 1, 8'h3c);
         send(pd);
         rc(1, 1, 8'hff, pd & 8'h3c);
         rc(0, 1, 8'hff, pd & 8'h3c);
         rc(0, 3, 8'h02, (pd == 8'hff) ? 8'h02 : 8'h00);
      end
      wr_reg(0, 2, 8'h5b);
      for (int i = 0; i < 4; i++) begin
         wr_reg(0, 0, CTL[i]);
         wr_reg(0, 3, 8'h01);
         if (i < 2) begin
            trig(8'h10);
            trig(8'h20);
         end
         if (i < 3) begin
            trig(8'h10);
         end
         pd = (i < 2) ? 8'h30 : (i < 3) ? 8'h20 : 8'h00;
         rc(0, 3, 8'h30, pd);
         wr_reg(0, 1, 8'hff);
         send(BYT[i]);
         rc(0, 1, 8'hff, BYT[i]);
         rc(0, 3, 8'hc9, STX[i]);
      end
      // device as master with bus mode off
      wr_reg(0, 0, 8'h09);
      wr_reg(0, 3, 8'h01);
      wr_reg(0, 1, 8'h6a);
      pd = 8'h00;
      for (int n = 0; n < 100 && pd[0] !== 1'b1; n++) begin
         rd_reg(0, 3, pd);
      end
      chk(pd & 8'h05, 8'h01);
      rc(0, 1, 8'hff, 8'h6a);
      tally_and_finish();
   end
endmodule
`default_nettype wire
